// ==== hw/pvc_map.svh ====
// Purpose: object indexes, bit positions, reset values, timing
// Assumes: one 25 MHz control clock
// Notes: included by the drive
`ifndef PVC_MAP_SVH
`define PVC_MAP_SVH
// ==========
// object indexes
`define PVC_IDX_CMD 16'h6040
`define PVC_IDX_STAT 16'h6041
`define PVC_IDX_MODE 16'h6060
`define PVC_IDX_MODE_RB 16'h6061
`define PVC_IDX_MPOS 16'h6063
`define PVC_IDX_UPOS 16'h6064
`define PVC_IDX_VDEM 16'h606b
`define PVC_IDX_VACT 16'h606c
`define PVC_IDX_VWIN 16'h606d
`define PVC_IDX_VWTIME 16'h606e
`define PVC_IDX_HOME 16'h607c
`define PVC_IDX_LIMIT 16'h607d
`define PVC_IDX_POL 16'h607e
`define PVC_IDX_MAXPROF 16'h607f
`define PVC_IDX_MAXMOT 16'h6080
`define PVC_IDX_ACC 16'h6083
`define PVC_IDX_DEC 16'h6084
`define PVC_IDX_TGT 16'h60ff
`define PVC_SUB_LOWER 8'h01
`define PVC_SUB_UPPER 8'h02
// ==========
// reset values
`define PVC_RST_VWIN 16'h000a
`define PVC_RST_LOWER 32'h8000_0000
`define PVC_RST_UPPER 32'h7fff_ffff
`define PVC_RST_MAXPROF 32'h7fff_ffff
`define PVC_RST_MAXMOT 32'h0000_2710
`define PVC_RST_RAMP 32'h00a0_0000
`define PVC_MODE_VEL 8'h03
// ==========
// control and status bit positions
`define PVC_CW_SWON 0
`define PVC_CW_VOLT 1
`define PVC_CW_QSTOP 2
`define PVC_CW_OPEN 3
`define PVC_CW_FRESET 7
`define PVC_CW_HALT 8
`define PVC_SW_READY 0
`define PVC_SW_SWON 1
`define PVC_SW_OPEN 2
`define PVC_SW_FAULT 3
`define PVC_SW_VOLT 4
`define PVC_SW_QSTOP 5
`define PVC_SW_SWDIS 6
`define PVC_SW_WARN 7
`define PVC_SW_REMOTE 9
`define PVC_SW_REACHED 10
`define PVC_SW_LIMIT 11
`define PVC_SW_ZERO 12
`define PVC_POL_VEL 6
// ==========
// timing
`define PVC_CLK_NS 40
`define PVC_TICK_NS 1000000
`define PVC_TICK_CYCLES (`PVC_TICK_NS / `PVC_CLK_NS)
`define PVC_RATE_SHIFT 8
`endif

// ==== hw/pvc_pkg.sv ====
// Purpose: carrier types of the velocity drive interface
// Assumes: pvc_map.svh holds the numbers
// Notes: none
package pvc_pkg;
   // ==========
   // object access carriers and drive state type
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] data;
   } pvc_obj_req_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] data;
   } pvc_obj_rsp_t;
   typedef enum logic [2:0] {
      ST_SWDIS = 3'b000,
      ST_READY = 3'b001,
      ST_SWON = 3'b010,
      ST_OPEN = 3'b011,
      ST_QSTOP = 3'b100,
      ST_FAULT = 3'b101
   } pvc_state_t;
endpackage

// ==== hw/pvc_drive.sv ====
// Purpose: control/status of a servo drive in profile velocity mode
// Assumes: feedback inputs come from logic on sys_clk
// Notes: velocity loop and fieldbus stack live outside
`timescale 1ns/100ps
`include "pvc_map.svh"
module pvc_drive #(
   parameter int TICK_CYCLES = `PVC_TICK_CYCLES,
   parameter int RATE_SHIFT = `PVC_RATE_SHIFT
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire pvc_pkg::pvc_obj_req_t objReq,
   output pvc_pkg::pvc_obj_rsp_t objRsp,
   input wire logic signed [31:0] velActual,
   input wire logic signed [31:0] motorPos,
   input wire logic signed [31:0] userPos,
   input wire logic faultIn,
   input wire logic warningIn,
   input wire logic voltageOk,
   output logic driveEnable,
   output logic signed [31:0] velDemand,
   output logic [15:0] stateWord
);
   import pvc_pkg::*;

   initial begin
      if (TICK_CYCLES < 1 || RATE_SHIFT < 0 || RATE_SHIFT > 31) begin
         $error("pvc_drive: bad parameter");
      end
   end

   // ==========
   // host objects
   logic [15:0] cmd_reg;
   logic [7:0] mode_reg;
   logic [15:0] vwin_reg;
   logic [15:0] vwtime_reg;
   logic [31:0] home_reg;
   logic [31:0] lower_reg;
   logic [31:0] upper_reg;
   logic [7:0] pol_reg;
   logic [31:0] maxProf_reg;
   logic [31:0] maxMot_reg;
   logic [31:0] acc_reg;
   logic [31:0] dec_reg;
   logic [31:0] tgt_reg;
   logic signed [31:0] velAct_reg;
   logic signed [31:0] mpos_reg;
   logic signed [31:0] upos_reg;
   logic signed [31:0] demand_reg;
   logic [15:0] sw_reg;
   pvc_obj_rsp_t rsp_reg;
   pvc_state_t state_reg;
   pvc_state_t state_next;
   logic fresetPrev_reg;
   logic [31:0] tickCnt_reg;
   logic tick_reg;
   logic [15:0] winCnt_reg;
   logic enable_reg;

   wire isLimit = objReq.index == `PVC_IDX_LIMIT;
   wire subLo = objReq.sub == `PVC_SUB_LOWER;
   wire subHi = objReq.sub == `PVC_SUB_UPPER;
   wire wrCmd = objReq.wr && objReq.index == `PVC_IDX_CMD;
   wire wrMode = objReq.wr && objReq.index == `PVC_IDX_MODE;
   wire wrVwin = objReq.wr && objReq.index == `PVC_IDX_VWIN;
   wire wrVwtime = objReq.wr && objReq.index == `PVC_IDX_VWTIME;
   wire wrHome = objReq.wr && objReq.index == `PVC_IDX_HOME;
   wire wrLower = objReq.wr && isLimit && subLo;
   wire wrUpper = objReq.wr && isLimit && subHi;
   wire wrPol = objReq.wr && objReq.index == `PVC_IDX_POL;
   wire wrMaxProf = objReq.wr && objReq.index == `PVC_IDX_MAXPROF;
   wire wrMaxMot = objReq.wr && objReq.index == `PVC_IDX_MAXMOT;
   wire wrAcc = objReq.wr && objReq.index == `PVC_IDX_ACC;
   wire wrDec = objReq.wr && objReq.index == `PVC_IDX_DEC;
   wire wrTgt = objReq.wr && objReq.index == `PVC_IDX_TGT;

   // ==========
   // object read selection
   logic [32:0] rdSel;
   always_comb begin
      rdSel = {1'b0, 32'h0000_0000};
      unique case (objReq.index)
         `PVC_IDX_CMD: rdSel = {1'b0, 16'h0000, cmd_reg};
         `PVC_IDX_STAT: rdSel = {1'b0, 16'h0000, sw_reg};
         `PVC_IDX_MODE: rdSel = {1'b0, 24'h00_0000, mode_reg};
         `PVC_IDX_MODE_RB: rdSel = {1'b0, 24'h00_0000, mode_reg};
         `PVC_IDX_MPOS: rdSel = {1'b0, mpos_reg};
         `PVC_IDX_UPOS: rdSel = {1'b0, upos_reg};
         `PVC_IDX_VDEM: rdSel = {1'b0, demand_reg};
         `PVC_IDX_VACT: rdSel = {1'b0, velAct_reg};
         `PVC_IDX_VWIN: rdSel = {1'b0, 16'h0000, vwin_reg};
         `PVC_IDX_VWTIME: rdSel = {1'b0, 16'h0000, vwtime_reg};
         `PVC_IDX_HOME: rdSel = {1'b0, home_reg};
         `PVC_IDX_LIMIT: begin
            rdSel = subLo ? {1'b0, lower_reg} : subHi ? {1'b0, upper_reg}
                          : {1'b1, 32'h0000_0000};
         end
         `PVC_IDX_POL: rdSel = {1'b0, 24'h00_0000, pol_reg};
         `PVC_IDX_MAXPROF: rdSel = {1'b0, maxProf_reg};
         `PVC_IDX_MAXMOT: rdSel = {1'b0, maxMot_reg};
         `PVC_IDX_ACC: rdSel = {1'b0, acc_reg};
         `PVC_IDX_DEC: rdSel = {1'b0, dec_reg};
         `PVC_IDX_TGT: rdSel = {1'b0, tgt_reg};
         default: rdSel = {1'b1, 32'h0000_0000};
      endcase
   end

   // writes to read-only or unknown objects answer with err
   wire wrKnown = wrCmd | wrMode | wrVwin | wrVwtime | wrHome | wrLower
                | wrUpper | wrPol | wrMaxProf | wrMaxMot | wrAcc | wrDec | wrTgt;
   pvc_obj_rsp_t rsp_next;
   assign rsp_next.valid = objReq.wr | objReq.rd;
   assign rsp_next.err = objReq.wr ? ~wrKnown : (objReq.rd & rdSel[32]);
   assign rsp_next.data = objReq.rd ? rdSel[31:0] : 32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cmd_reg <= 16'h0000;
         mode_reg <= 8'h00;
         vwin_reg <= `PVC_RST_VWIN;
         vwtime_reg <= 16'h0000;
         home_reg <= 32'h0000_0000;
         lower_reg <= `PVC_RST_LOWER;
         upper_reg <= `PVC_RST_UPPER;
         pol_reg <= 8'h00;
         maxProf_reg <= `PVC_RST_MAXPROF;
         maxMot_reg <= `PVC_RST_MAXMOT;
         acc_reg <= `PVC_RST_RAMP;
         dec_reg <= `PVC_RST_RAMP;
         tgt_reg <= 32'h0000_0000;
         rsp_reg <= '0;
      end else begin
         if (wrCmd) cmd_reg <= objReq.data[15:0];
         if (wrMode) mode_reg <= objReq.data[7:0];
         if (wrVwin) vwin_reg <= objReq.data[15:0];
         if (wrVwtime) vwtime_reg <= objReq.data[15:0];
         if (wrHome) home_reg <= objReq.data;
         if (wrLower) lower_reg <= objReq.data;
         if (wrUpper) upper_reg <= objReq.data;
         if (wrPol) pol_reg <= objReq.data[7:0];
         if (wrMaxProf) maxProf_reg <= objReq.data;
         if (wrMaxMot) maxMot_reg <= objReq.data;
         if (wrAcc) acc_reg <= objReq.data;
         if (wrDec) dec_reg <= objReq.data;
         if (wrTgt) tgt_reg <= objReq.data;
         rsp_reg <= rsp_next;
      end
   end

   // ==========
   // feedback capture
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         velAct_reg <= 32'sh0000_0000;
         mpos_reg <= 32'sh0000_0000;
         upos_reg <= 32'sh0000_0000;
      end else begin
         velAct_reg <= velActual;
         mpos_reg <= motorPos;
         upos_reg <= userPos;
      end
   end

   // ==========
   // control word decode
   // bits 4-6 and 9-15 are never decoded here
   wire modeVel = mode_reg == `PVC_MODE_VEL;
   wire fresetLvl = cmd_reg[`PVC_CW_FRESET];
   wire resetRise = fresetLvl & ~fresetPrev_reg;
   wire cSwon = cmd_reg[`PVC_CW_SWON];
   wire cVolt = cmd_reg[`PVC_CW_VOLT];
   wire cQs = cmd_reg[`PVC_CW_QSTOP];
   wire cOpen = cmd_reg[`PVC_CW_OPEN];
   wire halt = cmd_reg[`PVC_CW_HALT];
   wire cmdShutdown = cVolt & cQs & ~cSwon;
   wire cmdSwitchOn = cVolt & cQs & cSwon & ~cOpen;
   wire cmdEnable = cVolt & cQs & cSwon & cOpen;
   wire cmdQuick = cVolt & ~cQs;
   wire demandZero = demand_reg == 32'sh0000_0000;

   always_comb begin
      state_next = state_reg;
      if (faultIn) begin
         state_next = ST_FAULT;
      end else if (state_reg == ST_FAULT) begin
         if (resetRise) state_next = ST_SWDIS;
      end else if (!modeVel) begin
         state_next = ST_SWDIS;
      end else if (!fresetLvl) begin
         unique case (state_reg)
            ST_SWDIS: if (cmdShutdown) state_next = ST_READY;
            ST_READY: begin
               if (!cVolt) state_next = ST_SWDIS;
               else if (cmdSwitchOn) state_next = ST_SWON;
               else if (cmdEnable) state_next = ST_OPEN;
            end
            ST_SWON: begin
               if (!cVolt || cmdQuick) state_next = ST_SWDIS;
               else if (cmdShutdown) state_next = ST_READY;
               else if (cmdEnable) state_next = ST_OPEN;
            end
            ST_OPEN: begin
               if (!cVolt) state_next = ST_SWDIS;
               else if (cmdQuick) state_next = ST_QSTOP;
               else if (cmdShutdown) state_next = ST_READY;
               else if (cmdSwitchOn) state_next = ST_SWON;
            end
            ST_QSTOP: begin
               if (!cVolt || demandZero) state_next = ST_SWDIS;
            end
            default: state_next = ST_SWDIS;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= ST_SWDIS;
         fresetPrev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         fresetPrev_reg <= fresetLvl;
      end
   end

   // ==========
   // ramp generator
   wire running = state_reg == ST_OPEN;
   wire [31:0] ceilU = maxProf_reg[31] ? 32'h7fff_ffff : maxProf_reg;
   wire signed [31:0] ceilS = $signed(ceilU);
   wire signed [31:0] tgtPol = pol_reg[`PVC_POL_VEL] ? -$signed(tgt_reg) : $signed(tgt_reg);
   wire signed [31:0] tgtClamp = (tgtPol > ceilS) ? ceilS
                               : (tgtPol < -ceilS) ? -ceilS : tgtPol;
   // halt, quick stop and disabled all aim at zero velocity
   wire signed [31:0] aim = (running && !halt) ? tgtClamp : 32'sh0000_0000;
   wire signed [32:0] diff = {aim[31], aim} - {demand_reg[31], demand_reg};
   wire awayFromZero = (demand_reg >= 0 && diff > 0) || (demand_reg <= 0 && diff < 0);
   wire [31:0] rate = awayFromZero ? acc_reg : dec_reg;
   wire [31:0] stepRaw = rate >> RATE_SHIFT;
   wire [32:0] stepU = {1'b0, (stepRaw == 32'h0000_0000) ? 32'h0000_0001 : stepRaw};
   wire [32:0] diffAbs = diff[32] ? 33'(-diff) : 33'(diff);
   wire [32:0] stepUse = (diffAbs < stepU) ? diffAbs : stepU;
   wire signed [32:0] demandWide = {demand_reg[31], demand_reg};
   wire signed [32:0] demandStep = diff[32] ? demandWide - $signed(stepUse)
                                            : demandWide + $signed(stepUse);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tickCnt_reg <= 32'h0000_0000;
         tick_reg <= 1'b0;
         demand_reg <= 32'sh0000_0000;
      end else begin
         tick_reg <= tickCnt_reg == 32'(TICK_CYCLES - 1);
         tickCnt_reg <= (tickCnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                                                               : tickCnt_reg + 32'h0000_0001;
         // fault or switch on disabled drops demand at once, no ramp
         if (state_reg == ST_FAULT || state_reg == ST_SWDIS)
            demand_reg <= 32'sh0000_0000;
         else if (tick_reg)
            demand_reg <= demandStep[31:0];
      end
   end

   // ==========
   // target window and status word
   wire signed [32:0] errV = {velAct_reg[31], velAct_reg} - {tgtClamp[31], tgtClamp};
   wire [32:0] errAbs = errV[32] ? 33'(-errV) : 33'(errV);
   wire inWin = errAbs <= {17'h0_0000, vwin_reg};
   wire reached = inWin && winCnt_reg >= vwtime_reg;
   wire zeroVel = velActual == 32'sh0000_0000;
   wire limitHit = $signed(userPos) > $signed(upper_reg)
                || $signed(userPos) < $signed(lower_reg);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         winCnt_reg <= 16'h0000;
      end else if (!inWin) begin
         winCnt_reg <= 16'h0000;
      end else if (tick_reg && winCnt_reg != 16'hffff) begin
         winCnt_reg <= winCnt_reg + 16'h0001;
      end
   end

   logic [15:0] sw_next;
   always_comb begin
      sw_next = 16'h0000;
      sw_next[`PVC_SW_READY] = state_reg inside {ST_READY, ST_SWON, ST_OPEN, ST_QSTOP};
      sw_next[`PVC_SW_SWON] = state_reg inside {ST_SWON, ST_OPEN, ST_QSTOP};
      sw_next[`PVC_SW_OPEN] = state_reg inside {ST_OPEN, ST_QSTOP};
      sw_next[`PVC_SW_FAULT] = state_reg == ST_FAULT;
      sw_next[`PVC_SW_VOLT] = voltageOk;
      sw_next[`PVC_SW_QSTOP] = state_reg != ST_QSTOP;
      sw_next[`PVC_SW_SWDIS] = state_reg == ST_SWDIS;
      sw_next[`PVC_SW_WARN] = warningIn;
      sw_next[`PVC_SW_REMOTE] = modeVel && !fresetLvl;
      sw_next[`PVC_SW_REACHED] = halt ? zeroVel : reached;
      sw_next[`PVC_SW_LIMIT] = limitHit;
      sw_next[`PVC_SW_ZERO] = zeroVel;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sw_reg <= 16'h0000;
         enable_reg <= 1'b0;
      end else begin
         sw_reg <= sw_next;
         enable_reg <= state_next inside {ST_OPEN, ST_QSTOP};
      end
   end

   assign objRsp = rsp_reg;
   assign driveEnable = enable_reg;
   assign velDemand = demand_reg;
   assign stateWord = sw_reg;

   // ==========
   // checks
   property p_fault_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_reg == ST_FAULT && !resetRise) |=> state_reg == ST_FAULT;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left without reset edge");

   property p_reset_once;
      @(posedge sys_clk) disable iff (sys_rst)
      (resetRise && state_reg == ST_FAULT && !faultIn) |=> !resetRise ##0 state_reg == ST_SWDIS;
   endproperty
   a_reset_once: assert property (p_reset_once) else $error("fault reset not single");

   property p_reset_masks;
      @(posedge sys_clk) disable iff (sys_rst)
      (fresetLvl && !faultIn && modeVel && state_reg != ST_FAULT) |=> $stable(state_reg);
   endproperty
   a_reset_masks: assert property (p_reset_masks) else $error("control acted during reset bit");

   property p_op_flag;
      @(posedge sys_clk) disable iff (sys_rst)
      state_reg == ST_OPEN |=> sw_reg[`PVC_SW_OPEN] && sw_reg[`PVC_SW_QSTOP];
   endproperty
   a_op_flag: assert property (p_op_flag) else $error("operation flag wrong");

   property p_qstop_flag;
      @(posedge sys_clk) disable iff (sys_rst)
      state_reg == ST_QSTOP |=> !sw_reg[`PVC_SW_QSTOP];
   endproperty
   a_qstop_flag: assert property (p_qstop_flag) else $error("quick stop flag wrong");

   property p_zero_flag;
      @(posedge sys_clk) disable iff (sys_rst)
      velActual == 32'sh0000_0000 |=> sw_reg[`PVC_SW_ZERO] && (!$past(halt) || sw_reg[`PVC_SW_REACHED]);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero velocity flag wrong");

   property p_ramp_tick;
      @(posedge sys_clk) disable iff (sys_rst)
      (!tick_reg && state_reg inside {ST_OPEN, ST_QSTOP, ST_READY, ST_SWON}) |=> $stable(demand_reg);
   endproperty
   a_ramp_tick: assert property (p_ramp_tick) else $error("demand moved off tick");

   property p_halt_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      (halt && running && demandZero) |=> demandZero;
   endproperty
   a_halt_zero: assert property (p_halt_zero) else $error("demand left zero while halted");

   property p_mode_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (!modeVel && !faultIn && state_reg != ST_FAULT) |=> state_reg == ST_SWDIS ##1 !enable_reg;
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("enabled outside velocity mode");

   property p_window;
      @(posedge sys_clk) disable iff (sys_rst)
      (!halt && !inWin) |=> !sw_reg[`PVC_SW_REACHED];
   endproperty
   a_window: assert property (p_window) else $error("reached outside window");
endmodule

// ==== test/pvc_host_model.sv ====
// Purpose: fieldbus host model for the drive object bus
// Assumes: requests launched at the falling edge, one at a time
// Notes: each request is a one-cycle strobe; the answer is awaited under a bound
`timescale 1ns/100ps
module pvc_host_model (
   input wire logic sys_clk,
   output pvc_pkg::pvc_obj_req_t objReq,
   input wire pvc_pkg::pvc_obj_rsp_t objRsp
);
   import pvc_pkg::*;
   // ==========
   // object access
   initial objReq = '0;
   task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                         output pvc_obj_rsp_t r);
      @(negedge sys_clk);
      objReq <= '{wr: w, rd: !w, index: idx, sub: sub, data: d};
      // answer stands only in the cycle after the taking edge
      @(posedge sys_clk);
      #1;
      r = objRsp;
      @(negedge sys_clk);
      objReq <= '0;
      // bound so a lost answer shows as a mismatch, not a hang
      for (int n = 0; n < 3 && r.valid !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
         r = objRsp;
      end
   endtask
   // ==========
   // enable sequence, quick stop bit kept high
   task automatic enableDrive();
      pvc_obj_rsp_t r;
      access(1'b1, 16'h6040, 8'h00, 32'h0000_0006, r);
      access(1'b1, 16'h6040, 8'h00, 32'h0000_0007, r);
      access(1'b1, 16'h6040, 8'h00, 32'h0000_000f, r);
   endtask
endmodule

// ==== test/tb_profile_velocity_control_status.sv ====
// Purpose: self-checking bench of the velocity drive control and status
// Assumes: velocity loop modelled as actual following demand by half a cycle
// Notes: short tick period keeps ramps within a few hundred cycles
`timescale 1ns/100ps
module tb_profile_velocity_control_status;
   import pvc_pkg::*;
   logic sys_clk, sys_rst, faultIn, warningIn, voltageOk, driveEnable;
   pvc_obj_req_t objReq;
   pvc_obj_rsp_t objRsp, rsp;
   logic signed [31:0] velActual, motorPos, userPos, velDemand;
   logic [15:0] stateWord;
   int errCount = 0;
   int checks = 0;
   int cycles = 0;
   int tgt;
   localparam logic [63:0] RST_TAB [15] = '{
      64'h6040_0000_0000_0000, 64'h6060_0000_0000_0000, 64'h606b_0000_0000_0000,
      64'h606c_0000_0000_0000, 64'h606d_0000_0000_000a, 64'h606e_0000_0000_0000,
      64'h607c_0000_0000_0000, 64'h607d_0001_8000_0000, 64'h607d_0002_7fff_ffff,
      64'h607e_0000_0000_0000, 64'h607f_0000_7fff_ffff, 64'h6080_0000_0000_2710,
      64'h6083_0000_00a0_0000, 64'h6084_0000_00a0_0000, 64'h60ff_0000_0000_0000};
   localparam logic [63:0] BAD_TAB [8] = '{
      64'h6041_0000_0000_0001, 64'h6061_0000_0000_0001, 64'h6063_0000_0000_0001,
      64'h6064_0000_0000_0001, 64'h606b_0000_0000_0001, 64'h606c_0000_0000_0001,
      64'h607d_0003_0000_0001, 64'h1234_0000_0000_0001};

   pvc_drive #(.TICK_CYCLES(4), .RATE_SHIFT(8)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .objReq(objReq),
      .objRsp(objRsp), .velActual(velActual), .motorPos(motorPos), .userPos(userPos), .faultIn(faultIn),
      .warningIn(warningIn), .voltageOk(voltageOk), .driveEnable(driveEnable), .velDemand(velDemand),
      .stateWord(stateWord));
   pvc_host_model i_host (.sys_clk(sys_clk), .objReq(objReq), .objRsp(objRsp));

   // ==========
   // clock, loop model, hang guard
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) velActual <= velDemand;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         errCount++;
         endOfTest();
      end
   end

   // ==========
   // expectations and comparisons
   function automatic int step(input logic [31:0] rate);
      return (rate >> 8) == 0 ? 1 : int'(rate >> 8);
   endfunction
   task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic stat(input logic [15:0] m, input logic [15:0] e);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("state word", {17'h0_0000, e}, {17'h0_0000, stateWord & m});
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
      i_host.access(1'b1, idx, sub, d, rsp);
      chk($sformatf("write %h.%h", idx, sub), {31'h0, 1'b1, e}, {31'h0, rsp.valid, rsp.err});
   endtask
   task automatic cw(input logic [31:0] d);
      wr(16'h6040, 8'h00, d, 1'b0);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
      i_host.access(1'b0, idx, sub, 32'h0000_0000, rsp);
      chk($sformatf("read %h.%h", idx, sub), {1'b1, e}, {rsp.valid, rsp.data});
   endtask
   // demand must move by at most one step per cycle and settle on fin
   task automatic ramp(input int stp, input logic signed [31:0] fin);
      logic signed [31:0] prev;
      int bad;
      bad = 0;
      prev = velDemand;
      for (int i = 0; i < 600 && velDemand !== fin; i++) begin
         @(posedge sys_clk);
         #1;
         if (velDemand - prev > stp || prev - velDemand > stp) bad++;
         prev = velDemand;
      end
      chk("ramp step", 33'h0, {1'b0, 32'(bad)});
      chk("ramp end", {1'b0, fin}, {1'b0, velDemand});
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========
   // main sequence
   initial begin
      sys_rst = 1'b1;
      motorPos = 0;
      userPos = 0;
      faultIn = 1'b0;
      warningIn = 1'b0;
      voltageOk = 1'b1;
      void'($urandom(12621));
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 1'b0;
      foreach (RST_TAB[i]) rd(RST_TAB[i][63:48], RST_TAB[i][39:32], RST_TAB[i][31:0]);
      foreach (BAD_TAB[i]) wr(BAD_TAB[i][63:48], BAD_TAB[i][39:32], BAD_TAB[i][31:0], 1'b1);
      @(negedge sys_clk) motorPos = $urandom;
      rd(16'h6063, 8'h00, motorPos);
      cw(32'h0000_0006);
      stat(16'h025f, 16'h0050);
      wr(16'h6060, 8'h00, 32'h0000_0003, 1'b0);
      rd(16'h6061, 8'h00, 32'h0000_0003);
      cw(32'h0000_0006);
      stat(16'h027f, 16'h0231);
      cw(32'h0000_0007);
      stat(16'h027f, 16'h0233);
      cw(32'h0000_000f);
      stat(16'h027f, 16'h0237);
      cw(32'h0000_067f);
      stat(16'h027f, 16'h0237);
      chk("drive enable", 33'h0_0000_0001, {32'h0, driveEnable});
      tgt = $urandom_range(40, 30);
      wr(16'h607f, 8'h00, 32'h0000_000c, 1'b0);
      wr(16'h6083, 8'h00, 32'h0000_0400, 1'b0);
      wr(16'h60ff, 8'h00, tgt, 1'b0);
      ramp(step(32'h0000_0400), 12);
      stat(16'h1400, 16'h0400);
      wr(16'h607f, 8'h00, 32'h7fff_ffff, 1'b0);
      stat(16'h0400, 16'h0000);
      ramp(step(32'h0000_0400), tgt);
      stat(16'h1400, 16'h0400);
      rd(16'h606b, 8'h00, tgt);
      rd(16'h606c, 8'h00, tgt);
      wr(16'h6084, 8'h00, 32'h0000_0200, 1'b0);
      cw(32'h0000_010f);
      stat(16'h0400, 16'h0000);
      ramp(step(32'h0000_0200), 0);
      stat(16'h1400, 16'h1400);
      cw(32'h0000_000f);
      ramp(step(32'h0000_0400), tgt);
      cw(32'h0000_000b);
      stat(16'h0020, 16'h0000);
      ramp(step(32'h0000_0200), 0);
      stat(16'h025f, 16'h0250);
      i_host.enableDrive();
      ramp(step(32'h0000_0400), tgt);
      @(negedge sys_clk) faultIn = 1'b1;
      warningIn = 1'b1;
      stat(16'h008c, 16'h0088);
      chk("demand in fault", 33'h0, {1'b0, velDemand});
      cw(32'h0000_0080);
      @(negedge sys_clk) faultIn = 1'b0;
      stat(16'h0008, 16'h0008);
      cw(32'h0000_0080);
      stat(16'h0008, 16'h0008);
      cw(32'h0000_0000);
      cw(32'h0000_0080);
      stat(16'h025f, 16'h0050);
      cw(32'h0000_0086);
      stat(16'h025f, 16'h0050);
      cw(32'h0000_0006);
      warningIn = 1'b0;
      stat(16'h02ff, 16'h0231);
      wr(16'h607d, 8'h02, 32'h0000_0064, 1'b0);
      @(negedge sys_clk) userPos = 101;
      stat(16'h0800, 16'h0800);
      @(negedge sys_clk) userPos = $urandom_range(100, 0);
      stat(16'h0800, 16'h0000);
      endOfTest();
   end
endmodule
